/* File: common/npr_pkg.sv */
// constants, types and decoders for the page pointer read/program host
// Summary of operation
// - host opens main read with 00H or 01H plus three address cycles.
// - host ends a sequential row read by raising chip select.
// - spare read walks pages; host re-issues main read to leave it.
// - host stops sequential reads at the end of a block.
// - program loads at most 528 bytes then programs the cells.
// - host programs a page at most twice main, three times spare while no other page is programmed in between.
// - host maps out the latest failing block; the system above rewrites it elsewhere.
// - program is 80H, three addresses, data, then 10H; bare 10H does nothing.
package npr_pkg;

   // -----------------------------------------------------------------
   // timing, in ns as specified, and derived cycle counts
   // -----------------------------------------------------------------
   localparam int CLK_NS      = 25;
   localparam int T_WP_NS     = 25;
   localparam int T_WC_NS     = 50;
   localparam int T_REA_NS    = 35;
   localparam int T_REH_NS    = 15;
   localparam int T_WB_NS     = 100;
   localparam int T_WHR_NS    = 60;
   localparam int T_CEH_NS    = 100;
   localparam int SYNC_STAGES = 2;

   localparam int WE_LO   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_HI   = (T_WC_NS + CLK_NS - 1) / CLK_NS - WE_LO;
   // read data passes the pin synchroniser, so the strobe stays low longer
   localparam int RE_LO   = (T_REA_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
   localparam int RE_HI   = (T_REH_NS + CLK_NS - 1) / CLK_NS;
   localparam int WB_CYC  = (T_WB_NS + CLK_NS - 1) / CLK_NS;
   localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
   localparam int CEH_CYC = (T_CEH_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [2:0] WE_RISE  = 3'(WE_LO);
   localparam logic [2:0] WE_LAST  = 3'(WE_LO + WE_HI - 1);
   localparam logic [2:0] RE_RISE  = 3'(RE_LO);
   localparam logic [2:0] RE_LAST  = 3'(RE_LO + RE_HI - 1);
   localparam logic [2:0] WB_LAST  = 3'(WB_CYC - 1);
   localparam logic [2:0] WHR_LAST = 3'(WHR_CYC - 1);
   localparam logic [2:0] CEH_LAST = 3'(CEH_CYC - 1);

   // -----------------------------------------------------------------
   // commands, columns, page layout
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_PTR_A   = 8'h00;
   localparam logic [7:0] CMD_PTR_B   = 8'h01;
   localparam logic [7:0] CMD_PTR_C   = 8'h50;
   localparam logic [7:0] CMD_LOAD    = 8'h80;
   localparam logic [7:0] CMD_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_STATUS  = 8'h70;

   localparam logic [9:0] COL_FIRST  = 10'h000;
   localparam logic [9:0] COL_HALF_B = 10'h100;
   localparam logic [9:0] COL_SPARE  = 10'h200;
   localparam logic [9:0] COL_LAST   = 10'h20F;
   localparam logic [9:0] PAGE_BYTES = 10'h210;
   localparam logic [4:0] BLK_PAGE_LAST = 5'h1F;
   localparam logic [1:0] ADDR_LAST     = 2'h2;
   localparam logic [1:0] MAX_MAIN_PART  = 2'h2;
   localparam logic [1:0] MAX_SPARE_PART = 2'h3;
   localparam int STAT_FAIL_BIT = 0;

   typedef enum logic [2:0] {
      OP_RD_A, OP_RD_B, OP_RD_C, OP_PG_A, OP_PG_B, OP_PG_C
   } npr_op_t;

   typedef struct packed {
      npr_op_t     op;
      logic [7:0]  column;
      logic [15:0] page;
      logic [9:0]  len;
   } npr_req_t;

   typedef struct packed {
      logic       ce_n;
      logic       cle;
      logic       ale;
      logic       we_n;
      logic       re_n;
      logic [7:0] io_out;
      logic       io_oe;
   } npr_pins_t;

   function automatic logic npr_is_prog(npr_op_t op);
      return op inside {OP_PG_A, OP_PG_B, OP_PG_C};
   endfunction : npr_is_prog

   function automatic logic npr_is_spare(npr_op_t op);
      return op inside {OP_RD_C, OP_PG_C};
   endfunction : npr_is_spare

   function automatic logic [7:0] npr_ptr_cmd(npr_op_t op);
      if (npr_is_spare(op)) return CMD_PTR_C;
      if (op inside {OP_RD_B, OP_PG_B}) return CMD_PTR_B;
      return CMD_PTR_A;
   endfunction : npr_ptr_cmd

   function automatic logic [9:0] npr_start_col(npr_op_t op,
                                                logic [7:0] column);
      if (npr_is_spare(op)) return COL_SPARE | {6'h00, column[3:0]};
      if (op inside {OP_RD_B, OP_PG_B}) return COL_HALF_B + {2'h0, column};
      return {2'h0, column};
   endfunction : npr_start_col

endpackage : npr_pkg

/* File: logic/npr_sync.sv */
// two-stage synchroniser for the pins that come back from the card
`timescale 1ns/100ps
module npr_sync #(
   parameter int W = 9
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : npr_sync

/* File: logic/npr_host.sv */
// host controller: page reads and page programs over the card pins
`timescale 1ns/100ps
module npr_host (
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic              req_valid,
   input  wire npr_pkg::npr_req_t req,
   input  wire logic              wr_valid,
   input  wire logic [7:0]        wr_data,
   input  wire logic              rb_pin,
   input  wire logic [7:0]        io_in,
   output npr_pkg::npr_pins_t     pins,
   output logic                   busy,
   output logic                   done,
   output logic                   fail,
   output logic                   wr_ready,
   output logic                   rd_valid,
   output logic [7:0]             rd_data
);

   typedef enum logic [3:0] {
      S_IDLE, S_PTR, S_LOAD_CMD, S_ADDR, S_DATA, S_CONF, S_WB, S_RDY,
      S_READ, S_STAT_CMD, S_STAT_WHR, S_STAT_RD, S_CEH
   } npr_state_t;

   npr_state_t       state;
   npr_pkg::npr_op_t op;
   logic [2:0]       tcnt;
   logic [1:0]       acnt;
   logic [15:0]      page;
   logic [9:0]       col;
   logic [9:0]       rem;
   logic [15:0]      last_page;
   logic [1:0]       cnt_main;
   logic [1:0]       cnt_spare;
   logic [8:0]       sync_q;
   logic             rb_s;
   logic [7:0]       io_s;
   logic             start_ok;
   logic             refuse;
   logic [7:0]       wbyte;
   logic             wcle;
   logic             wale;
   logic             wgo;
   logic [10:0]      bad_blk;
   logic             bad_vld;

   // -----------------------------------------------------------------
   // pin return path
   // -----------------------------------------------------------------
   npr_sync #(.W(9)) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     ({rb_pin, io_in}),
      .q     (sync_q)
   );
   assign rb_s = sync_q[8];
   assign io_s = sync_q[7:0];

   // -----------------------------------------------------------------
   // request checks
   // -----------------------------------------------------------------
   always_comb begin
      logic [10:0] span;
      logic [1:0]  used;
      logic        prog;
      logic        cap;
      logic        over;
      logic        mapped;
      span = {1'b0, npr_pkg::npr_start_col(req.op, req.column)}
             + {1'b0, req.len};
      prog = npr_pkg::npr_is_prog(req.op);
      used = 2'h0;
      if (req.page == last_page)
         used = npr_pkg::npr_is_spare(req.op) ? cnt_spare : cnt_main;
      cap  = prog && (used >= (npr_pkg::npr_is_spare(req.op)
                       ? npr_pkg::MAX_SPARE_PART
                       : npr_pkg::MAX_MAIN_PART));
      over = prog && (span > {1'b0, npr_pkg::PAGE_BYTES});
      // the latest block that failed to program takes no further programs
      mapped = prog && bad_vld && req.page[15:5] == bad_blk;
      start_ok = req_valid && state == S_IDLE && req.len != 10'h000
                 && !cap && !over && !mapped;
      refuse   = req_valid && state == S_IDLE && !start_ok;
   end

   // -----------------------------------------------------------------
   // byte driven in each write cycle
   // -----------------------------------------------------------------
   always_comb begin
      wbyte = 8'h00;
      wcle  = 1'b0;
      wale  = 1'b0;
      wgo   = 1'b0;
      case (state)
         S_PTR: begin
            wbyte = npr_pkg::npr_ptr_cmd(op);
            wcle  = 1'b1;
            wgo   = 1'b1;
         end
         S_LOAD_CMD: begin
            wbyte = npr_pkg::CMD_LOAD;
            wcle  = 1'b1;
            wgo   = 1'b1;
         end
         S_ADDR: begin
            wbyte = (acnt == 2'h0) ? col[7:0]
                  : (acnt == 2'h1) ? page[7:0] : page[15:8];
            wale  = 1'b1;
            wgo   = 1'b1;
         end
         S_DATA: begin
            wbyte = wr_data;
            wgo   = wr_valid || tcnt != 3'h0;
         end
         S_CONF: begin
            wbyte = npr_pkg::CMD_CONFIRM;
            wcle  = 1'b1;
            wgo   = 1'b1;
         end
         S_STAT_CMD: begin
            wbyte = npr_pkg::CMD_STATUS;
            wcle  = 1'b1;
            wgo   = 1'b1;
         end
         default: ;
      endcase
   end

   // -----------------------------------------------------------------
   // partial program bookkeeping, one page remembered
   // -----------------------------------------------------------------
   // no erase is issued from here, so a page stays capped until a
   // different page is programmed
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         last_page <= 16'h0000;
         cnt_main  <= 2'h0;
         cnt_spare <= 2'h0;
      end else if (start_ok && npr_pkg::npr_is_prog(req.op)) begin
         last_page <= req.page;
         if (req.page != last_page) begin
            cnt_main  <= npr_pkg::npr_is_spare(req.op) ? 2'h0 : 2'h1;
            cnt_spare <= npr_pkg::npr_is_spare(req.op) ? 2'h1 : 2'h0;
         end else if (npr_pkg::npr_is_spare(req.op)) begin
            cnt_spare <= cnt_spare + 2'h1;
         end else begin
            cnt_main <= cnt_main + 2'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // failed-block map-out
   // -----------------------------------------------------------------
   // only the latest failing block is remembered; rewriting its data
   // elsewhere is left to the system above
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bad_blk <= 11'h000;
         bad_vld <= 1'b0;
      end else if (state == S_STAT_RD && tcnt == npr_pkg::RE_RISE
                   && io_s[npr_pkg::STAT_FAIL_BIT]) begin
         bad_blk <= page[15:5];
         bad_vld <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // sequencer and pin drive
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state    <= S_IDLE;
         op       <= npr_pkg::OP_RD_A;
         tcnt     <= 3'h0;
         acnt     <= 2'h0;
         page     <= 16'h0000;
         col      <= 10'h000;
         rem      <= 10'h000;
         pins     <= '{ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, default: '0};
         busy     <= 1'b0;
         done     <= 1'b0;
         fail     <= 1'b0;
         wr_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data  <= 8'h00;
      end else begin
         done     <= 1'b0;
         wr_ready <= 1'b0;
         rd_valid <= 1'b0;
         if (wgo) begin
            tcnt <= tcnt + 3'h1;
            if (tcnt == 3'h0) begin
               pins.we_n   <= 1'b0;
               pins.cle    <= wcle;
               pins.ale    <= wale;
               pins.io_out <= wbyte;
               pins.io_oe  <= 1'b1;
               wr_ready    <= (state == S_DATA);
            end
            if (tcnt == npr_pkg::WE_RISE)
               pins.we_n <= 1'b1;
         end
         unique case (state)
            S_IDLE: begin
               fail <= refuse;
               done <= refuse;
               if (start_ok) begin
                  op        <= req.op;
                  page      <= req.page;
                  col       <= npr_pkg::npr_start_col(req.op, req.column);
                  rem       <= req.len;
                  busy      <= 1'b1;
                  pins.ce_n <= 1'b0;
                  state     <= S_PTR;
               end
            end
            S_PTR, S_LOAD_CMD, S_CONF, S_STAT_CMD, S_ADDR, S_DATA: begin
               if (wgo && tcnt == npr_pkg::WE_LAST) begin
                  tcnt <= 3'h0;
                  if (state == S_PTR)
                     state <= npr_pkg::npr_is_prog(op) ? S_LOAD_CMD : S_ADDR;
                  else if (state == S_LOAD_CMD)
                     state <= S_ADDR;
                  else if (state == S_CONF)
                     state <= S_WB;
                  else if (state == S_STAT_CMD)
                     state <= S_STAT_WHR;
                  else if (state == S_ADDR) begin
                     acnt <= acnt + 2'h1;
                     if (acnt == npr_pkg::ADDR_LAST) begin
                        acnt  <= 2'h0;
                        state <= npr_pkg::npr_is_prog(op) ? S_DATA : S_WB;
                     end
                  end else begin
                     rem <= rem - 10'h001;
                     if (rem == 10'h001)
                        state <= S_CONF;
                  end
               end
            end
            S_WB: begin
               pins.cle   <= 1'b0;
               pins.ale   <= 1'b0;
               pins.io_oe <= 1'b0;
               tcnt       <= tcnt + 3'h1;
               if (tcnt == npr_pkg::WB_LAST) begin
                  tcnt  <= 3'h0;
                  state <= S_RDY;
               end
            end
            S_RDY: begin
               if (rb_s)
                  state <= npr_pkg::npr_is_prog(op) ? S_STAT_CMD : S_READ;
            end
            S_READ: begin
               tcnt <= tcnt + 3'h1;
               if (tcnt == 3'h0)
                  pins.re_n <= 1'b0;
               if (tcnt == npr_pkg::RE_RISE) begin
                  pins.re_n <= 1'b1;
                  rd_data   <= io_s;
                  rd_valid  <= 1'b1;
               end
               if (tcnt == npr_pkg::RE_LAST) begin
                  tcnt <= 3'h0;
                  rem  <= rem - 10'h001;
                  col  <= col + 10'h001;
                  if (rem == 10'h001) begin
                     state <= S_CEH;
                  end else if (col == npr_pkg::COL_LAST) begin
                     if (page[4:0] == npr_pkg::BLK_PAGE_LAST) begin
                        state <= S_CEH;
                     end else begin
                        page  <= page + 16'h0001;
                        col   <= npr_pkg::npr_is_spare(op)
                                 ? npr_pkg::COL_SPARE
                                 : npr_pkg::COL_FIRST;
                        state <= S_WB;
                     end
                  end
               end
            end
            S_STAT_WHR: begin
               pins.cle   <= 1'b0;
               pins.io_oe <= 1'b0;
               tcnt       <= tcnt + 3'h1;
               if (tcnt == npr_pkg::WHR_LAST) begin
                  tcnt  <= 3'h0;
                  state <= S_STAT_RD;
               end
            end
            S_STAT_RD: begin
               tcnt <= tcnt + 3'h1;
               if (tcnt == 3'h0)
                  pins.re_n <= 1'b0;
               if (tcnt == npr_pkg::RE_RISE) begin
                  pins.re_n <= 1'b1;
                  fail      <= io_s[npr_pkg::STAT_FAIL_BIT];
                  tcnt      <= 3'h0;
                  state     <= S_CEH;
               end
            end
            S_CEH: begin
               pins.ce_n  <= 1'b1;
               pins.cle   <= 1'b0;
               pins.ale   <= 1'b0;
               pins.io_oe <= 1'b0;
               tcnt       <= tcnt + 3'h1;
               if (tcnt == npr_pkg::CEH_LAST) begin
                  tcnt  <= 3'h0;
                  busy  <= 1'b0;
                  done  <= 1'b1;
                  state <= S_IDLE;
               end
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   logic [9:0] nld;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         nld <= 10'h000;
      else if (state == S_IDLE)
         nld <= 10'h000;
      else if (wr_ready)
         nld <= nld + 10'h001;
   end

   sequence s_cmd(logic [7:0] b);
      pins.cle && !pins.we_n && pins.io_out == b;
   endsequence

   a_confirm_has_data: assert property (
      s_cmd(npr_pkg::CMD_CONFIRM) |-> nld != 10'h000)
      else $error("confirm issued with nothing loaded");
   a_load_then_addr: assert property (
      s_cmd(npr_pkg::CMD_LOAD) |-> ##[1:4] (pins.ale && !pins.we_n))
      else $error("load command not followed by address");
   a_load_limit: assert property (
      nld <= npr_pkg::PAGE_BYTES)
      else $error("more than a page loaded");
   a_ce_high_end: assert property (
      (state == S_CEH && tcnt != 3'h0) |-> pins.ce_n)
      else $error("chip select low at end of access");
   a_block_stop: assert property (
      ($past(state) == S_READ && state == S_WB) |-> page[4:0] != 5'h00)
      else $error("sequential read crossed a block");
   a_spare_column: assert property (
      (state == S_READ && npr_pkg::npr_is_spare(op))
      |-> col >= npr_pkg::COL_SPARE)
      else $error("spare read left the spare area");
   a_partial_cap: assert property (
      cnt_main <= npr_pkg::MAX_MAIN_PART
      && cnt_spare <= npr_pkg::MAX_SPARE_PART)
      else $error("partial program count exceeded");
   a_read_ptr_first: assert property (
      (state == S_ADDR && acnt == 2'h0 && tcnt == 3'h0
       && !npr_pkg::npr_is_prog(op)) |-> $past(state) == S_PTR)
      else $error("read address without pointer command");

endmodule : npr_host

/* File: tb/npr_card.sv */
// behavioural card model: pointer, page reads, page programs, status
`timescale 1ns/100ps
module npr_card #(
   parameter int LOAD_NS = 400,
   parameter int PROG_NS = 2000
) (
   input  wire logic       ce_n,
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       we_n,
   input  wire logic       re_n,
   input  wire logic [7:0] io,
   input  wire logic       fail_next,
   output logic      [7:0] dq,
   output logic            dq_en,
   output logic            rb
);
   typedef enum logic [1:0] {NPR_PA, NPR_PB, NPR_PC} npr_ptr_t;
   npr_ptr_t    ptr = NPR_PA;
   logic [7:0]  mem [logic [25:0]];
   logic [7:0]  adr [3];
   logic [9:0]  col = 10'h000;
   logic [15:0] page = 16'h0000;
   logic [1:0]  nadr = 2'h0;
   logic        loading = 1'b0;
   logic        loaded = 1'b0;
   logic        stat = 1'b0;
   logic        err = 1'b0;
   logic [7:0]  q = 8'h00;
   initial rb = 1'b1;

   function automatic logic [7:0] pat(logic [15:0] pg, logic [9:0] c);
      return pg[7:0] + c[7:0] ^ {6'h00, c[9:8]};
   endfunction : pat

   task automatic hold_busy(int ns);
      #20 rb = 1'b0;
      #(ns) rb = 1'b1;
   endtask : hold_busy

   // ----------------------------------------------------------------
   // command, address and data latch on write strobe rise
   // ----------------------------------------------------------------
   always @(posedge we_n) begin
      if (!ce_n && cle) begin
         stat = 1'b0;
         case (io)
            8'h00: begin ptr = NPR_PA; loading = 1'b0; nadr = 2'h0; end
            8'h01: begin ptr = NPR_PB; loading = 1'b0; nadr = 2'h0; end
            8'h50: begin ptr = NPR_PC; loading = 1'b0; nadr = 2'h0; end
            8'h80: begin loading = 1'b1; loaded = 1'b0; nadr = 2'h0; end
            8'h10: if (loaded) begin
               loading = 1'b0;
               loaded = 1'b0;
               err = fail_next;
               if (ptr != NPR_PC) ptr = NPR_PA;
               hold_busy(PROG_NS);
            end
            8'h70: stat = 1'b1;
            default: ;
         endcase
      end else if (!ce_n && ale) begin
         adr[nadr] = io;
         nadr = nadr + 2'h1;
         if (nadr == 2'h3) begin
            page = {io, adr[1]};
            col = (ptr == NPR_PC) ? {6'h20, adr[0][3:0]} :
                  {1'b0, ptr == NPR_PB, adr[0]};
            if (ptr == NPR_PB && !loading) ptr = NPR_PA;
            if (!loading) hold_busy(LOAD_NS);
         end
      end else if (!ce_n && loading) begin
         mem[{page, col}] = io;
         col = col + 10'h001;
         loaded = 1'b1;
      end
   end

   always @(negedge re_n) if (!ce_n) begin
      q = stat ? {2'h3, 5'h00, err} :
          (mem.exists({page, col}) ? mem[{page, col}] : pat(page, col));
   end

   always @(posedge re_n) if (!ce_n && !stat) begin
      col = col + 10'h001;
      if (col == 10'h210) begin
         col = (ptr == NPR_PC) ? 10'h200 : 10'h000;
         page = page + 16'h0001;
         hold_busy(LOAD_NS);
      end
   end

   // released bus shows the inverse so a stale value never matches
   assign dq_en = !ce_n && !re_n;
   assign dq = dq_en ? q : ~q;
endmodule : npr_card

/* File: tb/tb_npr_host.sv */
// self-checking bench for the page read and program host
`timescale 1ns/100ps
module tb_npr_host;
   logic               mclk = 1'b0;
   logic               rst_b = 1'b0;
   logic               req_valid = 1'b0;
   npr_pkg::npr_req_t  req = '0;
   logic               wr_valid = 1'b0;
   logic [7:0]         wr_data = 8'h00;
   logic               fail_next = 1'b0;
   logic [7:0]         dq;
   logic               dq_en;
   logic               rb;
   wire  [7:0]         io_bus;
   npr_pkg::npr_pins_t pins;
   logic               busy, done, fail, wr_ready, rd_valid;
   logic [7:0]         rd_data;
   logic [7:0]         rx [$];
   logic [7:0]         tx [$];
   int                 errors = 0;
   int                 n_tests = 0;
   int                 cyc;

   initial begin
      forever #12.5 mclk = ~mclk;
   end

   assign io_bus = pins.io_oe ? pins.io_out : dq;

   npr_host u_dut (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
      .req(req), .wr_valid(wr_valid), .wr_data(wr_data), .rb_pin(rb),
      .io_in(io_bus), .pins(pins), .busy(busy), .done(done), .fail(fail),
      .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data));

   npr_card u_card (.ce_n(pins.ce_n), .cle(pins.cle), .ale(pins.ale),
      .we_n(pins.we_n), .re_n(pins.re_n), .io(io_bus),
      .fail_next(fail_next), .dq(dq), .dq_en(dq_en), .rb(rb));

   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [7:0] pat(logic [15:0] pg, logic [9:0] c);
      return pg[7:0] + c[7:0] ^ {6'h00, c[9:8]};
   endfunction : pat

   // host and card driving the byte bus together would be contention
   always @(posedge mclk) if (rst_b === 1'b1) begin
      check("bus owners", 16'(pins.io_oe & dq_en), 16'h0000);
   end

   task automatic run(npr_pkg::npr_op_t op, logic [7:0] c, logic [15:0] pg,
                      logic [9:0] len);
      int k;
      int wi;
      wi = 0;
      rx.delete();
      @(posedge mclk);
      req_valid <= 1'b1;
      req <= '{op: op, column: c, page: pg, len: len};
      wr_valid <= (tx.size() > 0);
      if (tx.size() > 0) wr_data <= tx[0];
      @(posedge mclk);
      req_valid <= 1'b0;
      for (k = 0; k < 20000 && done !== 1'b1; k++) begin
         @(posedge mclk);
         if (done !== 1'b1) check("busy", 16'(busy), 16'h0001);
         if (rd_valid === 1'b1) rx.push_back(rd_data);
         if (wr_ready === 1'b1) begin
            wi++;
            wr_valid <= (wi < tx.size());
            if (wi < tx.size()) wr_data <= tx[wi];
         end
      end
      cyc = k;
      wr_valid <= 1'b0;
      tx.delete();
      if (k == 20000) begin
         errors++;
         complete_run();
      end
   endtask : run

   task automatic expect_rx(logic [15:0] pg, logic [9:0] c, logic [9:0] base,
                            int n);
      check("byte count", 16'(rx.size()), 16'(n));
      for (int i = 0; i < n && i < rx.size(); i++) begin
         check("read byte", {8'h00, rx[i]}, {8'h00, pat(pg, c)});
         c++;
         if (c == 10'h210) begin
            c = base;
            pg++;
         end
      end
   endtask : expect_rx

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_idle;
      check("ce_n idle", 16'(pins.ce_n), 16'h0001);
      check("io_oe idle", 16'(pins.io_oe), 16'h0000);
      check("busy idle", 16'(busy), 16'h0000);
   endtask : t_reset_idle

   task automatic t_read_main;
      run(npr_pkg::OP_RD_A, 8'h05, 16'h0003, 10'd3);
      expect_rx(16'h0003, 10'h005, 10'h000, 3);
      run(npr_pkg::OP_RD_B, 8'h10, 16'h0004, 10'd2);
      expect_rx(16'h0004, 10'h110, 10'h000, 2);
      run(npr_pkg::OP_RD_A, 8'h10, 16'h0004, 10'd1);
      expect_rx(16'h0004, 10'h010, 10'h000, 1);
   endtask : t_read_main

   task automatic t_spare_wrap;
      run(npr_pkg::OP_RD_C, 8'hAE, 16'h0005, 10'd4);
      expect_rx(16'h0005, 10'h20E, 10'h200, 4);
      run(npr_pkg::OP_RD_C, 8'h0F, 16'h001F, 10'd3);
      expect_rx(16'h001F, 10'h20F, 10'h200, 1);
      check("fail at block end", 16'(fail), 16'h0000);
   endtask : t_spare_wrap

   task automatic t_program;
      logic [7:0] d [3] = '{8'hA1, 8'hB2, 8'hC3};
      tx = '{8'hA1, 8'hB2, 8'hC3};
      run(npr_pkg::OP_PG_A, 8'h02, 16'h0010, 10'd3);
      check("program fail", 16'(fail), 16'h0000);
      run(npr_pkg::OP_RD_A, 8'h02, 16'h0010, 10'd3);
      check("readback count", 16'(rx.size()), 16'h0003);
      for (int i = 0; i < 3 && i < rx.size(); i++) begin
         check("readback", {8'h00, rx[i]}, {8'h00, d[i]});
      end
      tx = '{8'h5A, 8'h6B};
      run(npr_pkg::OP_PG_B, 8'h00, 16'h0009, 10'd2);
      run(npr_pkg::OP_RD_B, 8'h00, 16'h0009, 10'd2);
      check("half b count", 16'(rx.size()), 16'h0002);
      if (rx.size() == 2) begin
         check("half b byte0", {8'h00, rx[0]}, 16'h005A);
         check("half b byte1", {8'h00, rx[1]}, 16'h006B);
      end
      run(npr_pkg::OP_RD_A, 8'h00, 16'h0009, 10'd1);
      expect_rx(16'h0009, 10'h000, 10'h000, 1);
   endtask : t_program

   task automatic t_partial_limit;
      tx = '{8'h11};
      run(npr_pkg::OP_PG_A, 8'h40, 16'h0009, 10'd1);
      check("second partial fail", 16'(fail), 16'h0000);
      tx = '{8'h22};
      run(npr_pkg::OP_PG_A, 8'h41, 16'h0009, 10'd1);
      check("third partial refused", 16'(fail), 16'h0001);
      check("refusal latency", 16'(cyc), 16'h0001);
      run(npr_pkg::OP_RD_A, 8'h00, 16'h0000, 10'd0);
      check("empty read refused", 16'(fail), 16'h0001);
   endtask : t_partial_limit

   task automatic t_status_fail;
      fail_next <= 1'b1;
      tx = '{8'h33};
      run(npr_pkg::OP_PG_C, 8'h00, 16'h0020, 10'd1);
      check("status error bit", 16'(fail), 16'h0001);
      fail_next <= 1'b0;
      tx = '{8'h44};
      run(npr_pkg::OP_PG_A, 8'h00, 16'h003F, 10'h001);
      check("failed block mapped out", 16'(fail), 16'h0001);
      check("map-out latency", 16'(cyc), 16'h0001);
   endtask : t_status_fail

   initial begin
      repeat (12) @(posedge mclk);
      t_reset_idle();
      rst_b <= 1'b1;
      @(posedge mclk);
      t_read_main();
      t_spare_wrap();
      t_program();
      t_partial_limit();
      t_status_fail();
      complete_run();
   end
endmodule : tb_npr_host
